// File: core/i2c_cfg_pkg.sv
// Constants, register map and state encoding for the configuration slave port.
// Assumes a 20 MHz system clock and a single host master on the two-wire bus.
package i2c_cfg_pkg;

    // Clock and bus timing
    localparam int CLK_HZ = 20_000_000;
    localparam int BIT_RATE_KBPS = 400;
    localparam int SCL_HIGH_MIN_NS = 600;
    localparam int SCL_HIGH_MIN_CYC = (SCL_HIGH_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Slave address, fixed upper part
    localparam logic [3:0] DEV_ADDR_FIXED = 4'hc;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Register indices
    localparam logic [3:0] IDX_STATUS = 4'h0;
    localparam logic [3:0] IDX_SETUP = 4'h1;
    localparam logic [3:0] IDX_CTRL1 = 4'h2;
    localparam logic [3:0] IDX_CTRL2 = 4'h3;
    localparam logic [3:0] IDX_LED_A_HI = 4'h4;
    localparam logic [3:0] IDX_LED_A_LO = 4'h5;
    localparam logic [3:0] IDX_LED_B_HI = 4'h6;
    localparam logic [3:0] IDX_LED_B_LO = 4'h7;
    localparam logic [3:0] IDX_PARITY = 4'h8;

    // Reset values, status then the stored registers 1 to 8
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] REG_RESET [1:8] = '{8'h80, 8'h21, 8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // Status bit positions
    localparam int ST_SUPPLY = 7;
    localparam int ST_TEMP = 5;
    localparam int ST_SIG = 4;
    localparam int ST_SUP = 3;
    localparam int ST_REG = 1;
    localparam int ST_PAR = 0;
    localparam logic [7:0] STATUS_USED_MASK = 8'hbb;

    // Restart-delay select bit in both control registers: 1 means latched
    localparam int CTRL_LATCH_BIT = 2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_INDEX = 4'b0011,
        ST_INDEX_ACK = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WACK = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RACK = 4'b1000
    } link_state_type;

endpackage : i2c_cfg_pkg

// File: core/i2c_cfg_slave.sv
// Two-wire configuration slave with fault status register and output protection latches.
// Assumes the host is sole master, drives SCL, and fault inputs are asynchronous levels.
// Functional notes
// - Fast-mode transfers up to 400 kbit/s.
// - SDA open drain only; SCL input only.
// - Idle by default; START enters, STOP leaves.
// - Bytes eight bits, MSB first.
// - First byte: 7-bit address plus direction.
// - Receiver acknowledges on ninth clock.
// - Device acknowledges every written byte.
// - Read: ack address, transmit; host acks.
// - Address upper four bits fixed 1100.
// - Low address bits from select pins.
// - Four-bit index selects the nine registers.
// - Fault sets status bit, interrupt while set.
// - Completed status read clears gone, prior faults.
// - Bit 7 supply low while switch enabled.
// - Bit 7 also on enable rise, transitions.
// - Status bits 6 and 2 read zero.
// - Bit 5 overtemperature, disables power outputs.
// - Bit 4 signal cut-off, latched disables output.
// - Bit 3 supply cut-off, latched disables output.
// - Bit 1 regulator low; bit 0 parity.
// - Any register access releases latched cut-offs.
`timescale 1ns/1ns
`default_nettype none
module i2c_cfg_slave (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic addr_select_bit0_in,
    input wire logic addr_select_bit1_in,
    input wire logic addr_select_bit2_in,
    input wire logic supply_switch_en_in,
    input wire logic supply_line_below_in,
    input wire logic supply_line_above_in,
    input wire logic supply_line_transition_in,
    input wire logic overtemp_in,
    input wire logic temp_restart_ok_in,
    input wire logic signal_cutoff_in,
    input wire logic signal_restart_done_in,
    input wire logic supply_cutoff_in,
    input wire logic supply_restart_done_in,
    input wire logic regulator_low_in,
    input wire logic parity_error_in,
    output logic irq_out,
    output logic power_disable_out,
    output logic signal_out_disable_out,
    output logic supply_out_disable_out,
    output logic [7:0] fault_status_out,
    output logic [7:0] output_stage_setup_out,
    output logic [7:0] signal_line_control_out,
    output logic [7:0] aux_line_control_out,
    output logic [7:0] led_a_pattern_high_out,
    output logic [7:0] led_a_pattern_low_out,
    output logic [7:0] led_b_pattern_high_out,
    output logic [7:0] led_b_pattern_low_out,
    output logic [7:0] parity_check_out
);

    localparam int SCL_HIGH_MIN = i2c_cfg_pkg::SCL_HIGH_MIN_CYC;

    logic scl_s;
    logic sda_s;
    logic [14:0] misc_s;
    logic sa0;
    logic sa1;
    logic sa2;
    logic sw_en;
    logic line_below;
    logic line_above;
    logic line_trans;
    logic hot;
    logic temp_ok;
    logic sig_cut;
    logic sig_done;
    logic sup_cut;
    logic sup_done;
    logic reg_low;
    logic par_err;

    // Bus lines and fault levels all come from outside the clock domain
    pin_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
        .clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .pins_in({scl_in, sda_in}),
        .stable_out({scl_s, sda_s})
    );

    pin_sync #(.WIDTH(15), .INIT(15'h0000)) u_misc_sync (
        .clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .pins_in({addr_select_bit2_in, addr_select_bit1_in, addr_select_bit0_in, supply_switch_en_in,
                  supply_line_below_in, supply_line_above_in, supply_line_transition_in, overtemp_in,
                  temp_restart_ok_in, signal_cutoff_in, signal_restart_done_in, supply_cutoff_in,
                  supply_restart_done_in, regulator_low_in, parity_error_in}),
        .stable_out(misc_s)
    );

    assign {sa2, sa1, sa0, sw_en, line_below, line_above, line_trans, hot, temp_ok, sig_cut, sig_done,
            sup_cut, sup_done, reg_low, par_err} = misc_s;

    i2c_cfg_pkg::link_state_type state_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [3:0] index_q;
    logic oe_q;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] snap_q;
    logic sw_en_prev_q;
    logic irq_q;
    logic power_dis_q;
    logic sig_hold_q;
    logic sig_hold_d;
    logic sup_hold_q;
    logic sup_hold_d;
    logic [7:0] regs_q [1:8];

    // Bus events seen on the synchronised lines
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_done;
    logic addr_match;
    logic [6:0] my_addr;
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign byte_done = scl_fall & (bit_cnt_q == i2c_cfg_pkg::BITS_PER_BYTE);
    assign my_addr = {i2c_cfg_pkg::DEV_ADDR_FIXED, sa2, sa1, sa0};
    assign addr_match = (shift_q[7:1] == my_addr);

    // Register selection; unmapped indices read as zero and ignore writes
    logic idx_stored;
    logic [7:0] rd_data;
    logic wr_pulse;
    logic rd_done;
    logic access;
    assign idx_stored = (index_q >= i2c_cfg_pkg::IDX_SETUP) && (index_q <= i2c_cfg_pkg::IDX_PARITY);
    assign rd_data = (index_q == i2c_cfg_pkg::IDX_STATUS) ? (flags_q & i2c_cfg_pkg::STATUS_USED_MASK) :
                     idx_stored ? regs_q[index_q] : 8'h00;
    assign wr_pulse = (state_q == i2c_cfg_pkg::ST_WDATA) && byte_done;
    assign rd_done = (state_q == i2c_cfg_pkg::ST_RACK) && scl_rise;
    assign access = wr_pulse | rd_done;

    // Serial engine; the protocol is paced by host SCL edges only
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q <= i2c_cfg_pkg::ST_IDLE;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            index_q <= 4'h0;
            oe_q <= 1'b0;
            snap_q <= 8'h00;
        end
        else
        begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            if (stop_det)
            begin
                state_q <= i2c_cfg_pkg::ST_IDLE;
                oe_q <= 1'b0;
            end
            else if (start_det)
            begin
                state_q <= i2c_cfg_pkg::ST_ADDR;
                bit_cnt_q <= 4'h0;
                oe_q <= 1'b0;
            end
            else
            begin
                case (state_q)
                    i2c_cfg_pkg::ST_ADDR, i2c_cfg_pkg::ST_INDEX, i2c_cfg_pkg::ST_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        else if (byte_done)
                        begin
                            bit_cnt_q <= 4'h0;
                            if (state_q == i2c_cfg_pkg::ST_ADDR)
                            begin
                                // Foreign address: stay off the bus until the next START
                                state_q <= addr_match ? i2c_cfg_pkg::ST_ADDR_ACK : i2c_cfg_pkg::ST_IDLE;
                                oe_q <= addr_match;
                                index_q <= (addr_match && !shift_q[0]) ? i2c_cfg_pkg::IDX_STATUS : index_q;
                            end
                            else if (state_q == i2c_cfg_pkg::ST_INDEX)
                            begin
                                index_q <= shift_q[3:0];
                                state_q <= i2c_cfg_pkg::ST_INDEX_ACK;
                                oe_q <= 1'b1;
                            end
                            else
                            begin
                                state_q <= i2c_cfg_pkg::ST_WACK;
                                oe_q <= 1'b1;
                            end
                        end
                    end
                    i2c_cfg_pkg::ST_ADDR_ACK:
                    begin
                        if (scl_fall && shift_q[0])
                        begin
                            // Slave becomes transmitter after its own acknowledge
                            state_q <= i2c_cfg_pkg::ST_RDATA;
                            shift_q <= rd_data;
                            snap_q <= flags_q;
                            oe_q <= ~rd_data[7];
                            bit_cnt_q <= 4'h1;
                        end
                        else if (scl_fall)
                        begin
                            state_q <= i2c_cfg_pkg::ST_INDEX;
                            oe_q <= 1'b0;
                        end
                    end
                    i2c_cfg_pkg::ST_INDEX_ACK, i2c_cfg_pkg::ST_WACK:
                    begin
                        if (scl_fall)
                        begin
                            state_q <= i2c_cfg_pkg::ST_WDATA;
                            oe_q <= 1'b0;
                        end
                    end
                    i2c_cfg_pkg::ST_RDATA:
                    begin
                        if (byte_done)
                        begin
                            state_q <= i2c_cfg_pkg::ST_RACK;
                            oe_q <= 1'b0;
                        end
                        else if (scl_fall)
                        begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            oe_q <= ~shift_q[6];
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                    i2c_cfg_pkg::ST_RACK:
                    begin
                        if (rd_done)
                        begin
                            // Host not-acknowledge ends the read; return to idle until the next START
                            shift_q <= {7'h00, sda_s};
                        end
                        else if (scl_fall && !shift_q[0])
                        begin
                            state_q <= i2c_cfg_pkg::ST_RDATA;
                            shift_q <= rd_data;
                            snap_q <= flags_q;
                            oe_q <= ~rd_data[7];
                            bit_cnt_q <= 4'h1;
                        end
                        else if (scl_fall)
                        begin
                            state_q <= i2c_cfg_pkg::ST_IDLE;
                        end
                    end
                    default:
                    begin
                        oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Stored registers; writes to status or unmapped indices are dropped
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 1; i <= 8; i++)
            begin
                regs_q[i] <= i2c_cfg_pkg::REG_RESET[i];
            end
        end
        else if (wr_pulse && idx_stored)
        begin
            regs_q[index_q] <= shift_q;
        end
    end

    // Fault sources and conditions still present
    logic latched_sig;
    logic latched_sup;
    logic [7:0] set_vec;
    logic [7:0] present_vec;
    logic [7:0] clr_vec;
    assign latched_sig = regs_q[i2c_cfg_pkg::IDX_CTRL1][i2c_cfg_pkg::CTRL_LATCH_BIT];
    assign latched_sup = regs_q[i2c_cfg_pkg::IDX_CTRL2][i2c_cfg_pkg::CTRL_LATCH_BIT];
    assign set_vec = {(line_below & sw_en) | (sw_en & ~sw_en_prev_q) | line_trans,
                      1'b0, hot, sig_cut, sup_cut, 1'b0, reg_low, par_err};
    assign present_vec = {~line_above, 1'b0, ~temp_ok, ~(sig_done | latched_sig), ~(sup_done | latched_sup),
                          1'b0, reg_low, par_err};
    assign clr_vec = (rd_done && index_q == i2c_cfg_pkg::IDX_STATUS) ? (snap_q & ~present_vec) : 8'h00;

    // A new fault beats a clear in the same cycle
    assign flags_d = ((flags_q & ~clr_vec) | set_vec) & i2c_cfg_pkg::STATUS_USED_MASK;
    assign sig_hold_d = (sig_hold_q & ~access) | (sig_cut & latched_sig);
    assign sup_hold_d = (sup_hold_q & ~access) | (sup_cut & latched_sup);

    // Status flags and the outputs they steer
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            flags_q <= i2c_cfg_pkg::RST_STATUS;
            sw_en_prev_q <= 1'b0;
            irq_q <= 1'b0;
            power_dis_q <= 1'b0;
            sig_hold_q <= 1'b0;
            sup_hold_q <= 1'b0;
        end
        else
        begin
            flags_q <= flags_d;
            sw_en_prev_q <= sw_en;
            irq_q <= |flags_d;
            power_dis_q <= flags_d[i2c_cfg_pkg::ST_TEMP];
            sig_hold_q <= sig_hold_d;
            sup_hold_q <= sup_hold_d;
        end
    end

    // Outputs straight from flops; SDA only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_out = oe_q;
    assign irq_out = irq_q;
    assign power_disable_out = power_dis_q;
    assign signal_out_disable_out = sig_hold_q;
    assign supply_out_disable_out = sup_hold_q;
    assign fault_status_out = flags_q;
    assign output_stage_setup_out = regs_q[i2c_cfg_pkg::IDX_SETUP];
    assign signal_line_control_out = regs_q[i2c_cfg_pkg::IDX_CTRL1];
    assign aux_line_control_out = regs_q[i2c_cfg_pkg::IDX_CTRL2];
    assign led_a_pattern_high_out = regs_q[i2c_cfg_pkg::IDX_LED_A_HI];
    assign led_a_pattern_low_out = regs_q[i2c_cfg_pkg::IDX_LED_A_LO];
    assign led_b_pattern_high_out = regs_q[i2c_cfg_pkg::IDX_LED_B_HI];
    assign led_b_pattern_low_out = regs_q[i2c_cfg_pkg::IDX_LED_B_LO];
    assign parity_check_out = regs_q[i2c_cfg_pkg::IDX_PARITY];

    // Checks on the serial engine and status logic
    logic [4:0] high_cnt_q;
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            high_cnt_q <= 5'h00;
        end
        else
        begin
            high_cnt_q <= scl_s ? ((high_cnt_q == 5'h1f) ? high_cnt_q : high_cnt_q + 5'h01) : 5'h00;
        end
    end

    start_enter_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        start_det && !stop_det |=> state_q == i2c_cfg_pkg::ST_ADDR && !oe_q)
        else $error("START did not enter address phase");
    stop_idle_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        stop_det |=> state_q == i2c_cfg_pkg::ST_IDLE ##1 !oe_q)
        else $error("STOP did not return to idle");
    addr_ack_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        state_q == i2c_cfg_pkg::ST_ADDR && byte_done && !start_det && !stop_det |=> oe_q == $past(addr_match))
        else $error("Address acknowledge wrong");
    write_ack_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        wr_pulse && !start_det && !stop_det |=> oe_q && state_q == i2c_cfg_pkg::ST_WACK)
        else $error("Written byte not acknowledged");
    irq_follow_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        ##1 irq_out == ($past(flags_d) != 8'h00))
        else $error("Interrupt does not follow status");
    unused_zero_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !fault_status_out[6] && !fault_status_out[2])
        else $error("Unused status bit set");
    temp_disable_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        hot |=> power_disable_out && fault_status_out[i2c_cfg_pkg::ST_TEMP])
        else $error("Overtemperature did not disable power");
    read_clear_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        rd_done && index_q == i2c_cfg_pkg::IDX_STATUS && snap_q[i2c_cfg_pkg::ST_REG] && !reg_low
        |=> !fault_status_out[i2c_cfg_pkg::ST_REG])
        else $error("Status read did not clear gone fault");
    latch_release_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        access && !sig_cut |=> !signal_out_disable_out)
        else $error("Register access did not release latch");
    scl_high_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        scl_fall && state_q != i2c_cfg_pkg::ST_IDLE |-> high_cnt_q >= 5'(SCL_HIGH_MIN - 4))
        else $error("SCL high phase shorter than fast mode allows");

    read_seen_c: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) rd_done);
    write_seen_c: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) wr_pulse && idx_stored);
    clear_seen_c: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) clr_vec != 8'h00);
    latch_seen_c: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) sig_hold_q ##1 !sig_hold_q);

endmodule : i2c_cfg_slave
`default_nettype wire

// File: core/pin_sync.sv
// Three-stage synchroniser for a group of pins from outside the clock domain.
// Assumes each bit is slow against the clock; the output follows once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] stable_out
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] stable_q;
    logic [WIDTH-1:0] agree;

    // Bitwise agreement of the two settled stages
    assign agree = ~(s2_q ^ s3_q);
    assign stable_out = stable_q;

    // Stage one is read by stage two only
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            stable_q <= INIT;
        end
        else
        begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= (stable_q & ~agree) | (s3_q & agree);
        end
    end

endmodule : pin_sync
`default_nettype wire

// File: testbench/i2c_cfg_slave_tb_top.sv
// Bench for the configuration slave: registers, address match, fault flags and latches.
// Assumes the host model owns the bus; fault levels are driven here at falling clock edges.
`timescale 1ns/1ns
`default_nettype none
module i2c_cfg_slave_tb_top;
    logic clk, nrst, scl, host_low, sda_oe, irq, pwr, sig_dis, sup_dis, sw_en, trans, ack;
    logic [2:0] sa;
    logic [7:0] flt, ok, st, la, rd, dat;
    int n_fail, check_count;
    int bits [6] = '{7, 5, 4, 3, 1, 0};
    wire logic sda = ~(host_low | sda_oe); // Pull-up unless someone pulls low
    i2c_host_model i2c_host_model_i (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
    i2c_cfg_slave i2c_cfg_slave_i (
        .sys_clk_in(clk), .nrst_in(nrst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
        .addr_select_bit0_in(sa[0]), .addr_select_bit1_in(sa[1]), .addr_select_bit2_in(sa[2]),
        .supply_switch_en_in(sw_en), .supply_line_below_in(flt[7]), .supply_line_above_in(ok[7]),
        .supply_line_transition_in(trans), .overtemp_in(flt[5]), .temp_restart_ok_in(ok[5]),
        .signal_cutoff_in(flt[4]), .signal_restart_done_in(ok[4]), .supply_cutoff_in(flt[3]),
        .supply_restart_done_in(ok[3]), .regulator_low_in(flt[1]), .parity_error_in(flt[0]), .irq_out(irq),
        .power_disable_out(pwr), .signal_out_disable_out(sig_dis), .supply_out_disable_out(sup_dis),
        .fault_status_out(st), .output_stage_setup_out(), .signal_line_control_out(), .aux_line_control_out(),
        .led_a_pattern_high_out(la), .led_a_pattern_low_out(), .led_b_pattern_high_out(),
        .led_b_pattern_low_out(), .parity_check_out());
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    // One byte from the host; the device must acknowledge it
    task automatic send(input logic [7:0] b);
        i2c_host_model_i.xfer_byte(b, 1'b1, rd, ack);
        check({7'h00, ack}, 8'h00);
    endtask : send
    task automatic reg_write(input logic [3:0] idx, input logic [7:0] d);
        i2c_host_model_i.start_cond();
        send({4'hc, sa, 1'b0});
        send({4'h0, idx});
        send(d);
        i2c_host_model_i.stop_cond();
    endtask : reg_write
    // Index set by a write, then repeated start and a single byte closed with a not-acknowledge
    task automatic reg_read(input logic [3:0] idx, output logic [7:0] d);
        i2c_host_model_i.start_cond();
        send({4'hc, sa, 1'b0});
        send({4'h0, idx});
        i2c_host_model_i.start_cond();
        send({4'hc, sa, 1'b1});
        i2c_host_model_i.xfer_byte(8'hff, 1'b1, d, ack);
        i2c_host_model_i.stop_cond();
    endtask : reg_read
    // Hang guard, sized above the roughly 84k cycles the sequence needs
    initial
    begin
        repeat (95000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        nrst = 1'b0;
        sa = 3'h5;
        flt = 8'h00;
        ok = 8'h00;
        sw_en = 1'b0;
        trans = 1'b0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (10) @(negedge clk);
        check({7'h00, sda_oe}, 8'h00);
        for (int i = 0; i < 10; i++)
        begin
            reg_read(i[3:0], dat);
            check(dat, (i == 0) ? i2c_cfg_pkg::RST_STATUS : (i < 9) ? i2c_cfg_pkg::REG_RESET[i] : 8'h00);
        end
        for (int i = 1; i < 9; i++)
        begin
            reg_write(i[3:0], 8'h5a ^ i[7:0]);
            reg_read(i[3:0], dat);
            check(dat, 8'h5a ^ i[7:0]);
        end
        check(la, 8'h5e);
        // Wrong select bits, then wrong fixed part: both must go unanswered
        for (int i = 0; i < 2; i++)
        begin
            i2c_host_model_i.start_cond();
            i2c_host_model_i.xfer_byte(i ? {4'hd, sa, 1'b0} : {4'hc, ~sa, 1'b0}, 1'b1, rd, ack);
            check({7'h00, ack}, 8'h01);
            i2c_host_model_i.stop_cond();
        end
        // Enable rise, then a line transition pulse: each holds bit 7 until a read
        for (int t = 0; t < 2; t++)
        begin
            sw_en = 1'b1;
            trans = (t == 1);
            repeat (10) @(negedge clk);
            trans = 1'b0;
            check(st, 8'h80);
            ok[7] = 1'b1;
            reg_read(4'h0, dat);
            check(dat, 8'h80);
            check(st, 8'h00);
            ok[7] = 1'b0;
        end
        // Each fault: set, survive a read while present, clear on a read once gone
        foreach (bits[k])
        begin
            flt[bits[k]] = 1'b1;
            repeat (10) @(negedge clk);
            check(st, 8'h01 << bits[k]);
            check({6'h00, irq, pwr}, (bits[k] == 5) ? 8'h03 : 8'h02);
            reg_read(4'h0, dat);
            check(st, 8'h01 << bits[k]);
            flt[bits[k]] = 1'b0;
            ok[bits[k]] = 1'b1;
            reg_read(4'h0, dat);
            check(dat, 8'h01 << bits[k]);
            check({st[7:1], irq}, 8'h00);
        end
        // Latched cut-offs hold their output off until any register access
        reg_write(i2c_cfg_pkg::IDX_CTRL1, 8'h25);
        reg_write(i2c_cfg_pkg::IDX_CTRL2, 8'h25);
        for (int j = 3; j < 5; j++)
        begin
            flt[j] = 1'b1;
            repeat (10) @(negedge clk);
            flt[j] = 1'b0;
            repeat (10) @(negedge clk);
            check({6'h00, sig_dis, sup_dis}, (j == 4) ? 8'h02 : 8'h01);
            reg_write(i2c_cfg_pkg::IDX_LED_B_LO, 8'h3c);
            check({6'h00, sig_dis, sup_dis}, 8'h00);
        end
        tally_and_finish();
    end
endmodule : i2c_cfg_slave_tb_top
`default_nettype wire

// File: testbench/i2c_host_model.sv
// Host master model for the two-wire port: frames, bytes and acknowledge bits.
// Assumes a pull-up on SDA; the bench resolves the wire from both pull-downs.
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // Quarter bit rounded up so the host never exceeds the fast-mode rate
    localparam int QTR = (i2c_cfg_pkg::CLK_HZ / (i2c_cfg_pkg::BIT_RATE_KBPS * 1000) + 3) / 4;
    // Bus idles released; SCL stands still between frames
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic qtr();
        repeat (QTR) @(negedge clk_in);
    endtask : qtr
    // Start or repeated start; SDA moves a quarter after SCL to keep both apart through the sync
    task automatic start_cond();
        qtr();
        sda_low_out = 1'b0;
        qtr();
        scl_out = 1'b1;
        qtr();
        sda_low_out = 1'b1;
        qtr();
        scl_out = 1'b0;
    endtask : start_cond
    // Stop always follows at least one byte, never a bare start
    task automatic stop_cond();
        qtr();
        sda_low_out = 1'b1;
        qtr();
        scl_out = 1'b1;
        qtr();
        sda_low_out = 1'b0;
        qtr();
    endtask : stop_cond
    task automatic clock_bit(input logic b, output logic s);
        qtr();
        sda_low_out = ~b;
        qtr();
        scl_out = 1'b1;
        qtr();
        s = sda_in;
        qtr();
        scl_out = 1'b0;
    endtask : clock_bit
    // Eight bits MSB first, then the ninth clock; a reader releases SDA and sends ack_tx
    task automatic xfer_byte(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
        for (int i = 7; i >= 0; i--)
            clock_bit(tx[i], rx[i]);
        clock_bit(ack_tx, ack_rx);
    endtask : xfer_byte
endmodule : i2c_host_model
`default_nettype wire
